// >>> rtl/ssr_pkg.sv
// package: constants and types for the serial sram two-wire slave
package ssr_pkg;

  localparam int SSR_ADDR_W = 13;
  localparam int SSR_DATA_W = 8;
  localparam int SSR_DEPTH = 8192;
  localparam logic [3:0] SSR_OPCODE_ARRAY = 4'ha;
  localparam logic SSR_FIXED_CS = 1'b1;
  localparam logic SSR_RW_READ = 1'b1;
  localparam logic [SSR_ADDR_W-1:0] SSR_ADDR_LAST = 13'h1fff;
  localparam logic [SSR_ADDR_W-1:0] SSR_ADDR_ZERO = 13'h0000;
  localparam logic [SSR_ADDR_W-1:0] SSR_ADDR_ONE = 13'h0001;
  localparam logic [1:0] SSR_PROT_TOP = 2'h3;
  localparam logic [2:0] SSR_BIT_LAST = 3'h7;
  localparam logic [2:0] SSR_BIT_ZERO = 3'h0;
  localparam logic [SSR_DATA_W-1:0] SSR_BYTE_ZERO = 8'h00;

  // byte stage of one transfer
  typedef enum logic [6:0] {
    SSR_IDLE = 7'b000_0001,
    SSR_CTRL = 7'b000_0010,
    SSR_ADRH = 7'b000_0100,
    SSR_ADRL = 7'b000_1000,
    SSR_WDAT = 7'b001_0000,
    SSR_RDAT = 7'b010_0000,
    SSR_MACK = 7'b100_0000
  } ssr_state_type;

  // one write to the array, passed from link domain to system domain
  typedef struct packed {
    logic [SSR_ADDR_W-1:0] addr;
    logic [SSR_DATA_W-1:0] data;
  } ssr_wreq_type;

  // sampled pin levels of the two-wire bus
  typedef struct packed {
    logic scl;
    logic sda;
  } ssr_bus_type;

endpackage : ssr_pkg

// >>> rtl/ssr_sync.sv
// two flip-flop synchroniser for a bundle of levels
`timescale 1ns/1ps
module ssr_sync
  import ssr_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      dout <= '0;
    end
    else if (ce)
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule : ssr_sync

// >>> rtl/ssr_slave.sv
// two-wire serial sram slave: bus engine on scl domain, array on clk domain
`timescale 1ns/1ps
// How it works
// - control byte: opcode, cs2, cs1, one, rw
// - respond only when cs bits match pins
// - rw one reads, zero writes
// - acknowledge a valid slave address
// - low capacitor supply: control byte not acknowledged
// - backup start abandons current operation
// - two address bytes, msb first, into pointer
// - data committed at acknowledge rising edge
// - protected byte: nack, no increment, ignore
// - write protect blocks upper quarter
// - after byte write pointer is next
// - sequential write increments, wraps, unlimited
// - read starts at current pointer
// - master ack zero continues, one ends
// - pointer advances after each byte
// - shift out byte, stop on nack
// - repeated start keeps loaded pointer
// - sequential read wraps to zero
// - bad control byte: no further acks
// - after master nack release data high
// - no control byte ack during backup or restore
module ssr_slave
  import ssr_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic chip_select_upper_pin,
  input wire logic chip_select_lower_pin,
  input wire logic write_protect_pin,
  input wire logic supply_below_trip,
  input wire logic backup_busy,
  input wire logic power_loss_backup,
  output logic link_active_q
);

  // ------------------------------------------------------------
  // start and stop detection on the data line
  // ------------------------------------------------------------
  // start: sda falls while scl high; stop: sda rises while scl high
  logic start_tgl_q;
  logic stop_tgl_q;
  always_ff @(negedge sda_in or posedge sys_rst)
  begin
    if (sys_rst)
      start_tgl_q <= 1'b0;
    else if (scl_clk)
      start_tgl_q <= ~start_tgl_q;
  end
  always_ff @(posedge sda_in or posedge sys_rst)
  begin
    if (sys_rst)
      stop_tgl_q <= 1'b0;
    else if (scl_clk)
      stop_tgl_q <= ~stop_tgl_q;
  end

  // ------------------------------------------------------------
  // block controls crossed into the link domain
  // ------------------------------------------------------------
  logic [2:0] lk_ctl;
  ssr_sync #(.WIDTH(3)) u_sync_link (
    .clk(scl_clk),
    .rst(sys_rst),
    .ce(1'b1),
    .din({supply_below_trip | backup_busy, power_loss_backup, write_protect_pin}),
    .dout(lk_ctl)
  );
  logic [1:0] cs_sync;
  ssr_sync #(.WIDTH(2)) u_sync_cs (
    .clk(scl_clk),
    .rst(sys_rst),
    .ce(1'b1),
    .din({chip_select_upper_pin, chip_select_lower_pin}),
    .dout(cs_sync)
  );
  wire lk_busy = lk_ctl[2];
  wire lk_abort = lk_ctl[1];
  wire lk_wp = lk_ctl[0];

  // ------------------------------------------------------------
  // link side byte engine (scl rising edges)
  // ------------------------------------------------------------
  ssr_state_type st_q;
  logic [2:0] bit_q;
  logic [SSR_DATA_W-1:0] sh_q;
  logic [SSR_ADDR_W-1:0] ptr_q;
  logic ack_q;
  logic wr_pend_q;
  logic seen_start_q;
  logic seen_stop_q;
  logic wr_tgl_q;
  ssr_wreq_type wreq_q;
  logic [SSR_DATA_W-1:0] rd_byte_q;

  wire start_seen = start_tgl_q ^ seen_start_q;
  wire stop_seen = stop_tgl_q ^ seen_stop_q;
  wire byte_done = (bit_q == SSR_BIT_LAST);
  wire [SSR_DATA_W-1:0] sh_next = {sh_q[SSR_DATA_W-2:0], sda_in};
  wire ctrl_ok = (sh_next[7:4] == SSR_OPCODE_ARRAY) &&
                 (sh_next[3:2] == cs_sync) && (sh_next[1] == SSR_FIXED_CS);
  wire ctrl_rd = (sh_next[0] == SSR_RW_READ);
  // upper quarter blocked while protect pin high
  wire prot_hit = lk_wp && (ptr_q[SSR_ADDR_W-1:SSR_ADDR_W-2] == SSR_PROT_TOP);
  // natural 13-bit wrap from last to zero
  wire [SSR_ADDR_W-1:0] ptr_inc = ptr_q + SSR_ADDR_ONE;
  wire [SSR_DATA_W-1:0] rd_data;

  // ack pending drives sda on falling edge
  always_ff @(posedge scl_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= SSR_IDLE;
      bit_q <= SSR_BIT_ZERO;
      sh_q <= SSR_BYTE_ZERO;
      ptr_q <= SSR_ADDR_ZERO;
      ack_q <= 1'b0;
      wr_pend_q <= 1'b0;
      seen_start_q <= 1'b0;
      seen_stop_q <= 1'b0;
      wr_tgl_q <= 1'b0;
      wreq_q <= '0;
      rd_byte_q <= SSR_BYTE_ZERO;
    end
    else
    begin
      seen_start_q <= start_tgl_q;
      seen_stop_q <= stop_tgl_q;
      ack_q <= 1'b0;
      wr_pend_q <= 1'b0;
      if (lk_abort)
      begin
        st_q <= SSR_IDLE;
        bit_q <= SSR_BIT_ZERO;
      end
      else if (start_seen)
      begin
        // repeated start keeps pointer, first bit of control byte
        st_q <= SSR_CTRL;
        bit_q <= 3'h1;
        sh_q <= {SSR_BYTE_ZERO[SSR_DATA_W-2:0], sda_in};
      end
      else if (stop_seen)
      begin
        st_q <= SSR_IDLE;
        bit_q <= SSR_BIT_ZERO;
      end
      // acknowledge clock carries no data bit, count restarts
      else if (ack_q)
        bit_q <= SSR_BIT_ZERO;
      else
      begin
        case (st_q)
          SSR_CTRL, SSR_ADRH, SSR_ADRL, SSR_WDAT:
          begin
            sh_q <= sh_next;
            bit_q <= bit_q + 3'h1;
            if (byte_done)
            begin
              case (st_q)
                SSR_CTRL:
                begin
                  if (ctrl_ok && !lk_busy)
                  begin
                    ack_q <= 1'b1;
                    st_q <= ctrl_rd ? SSR_RDAT : SSR_ADRH;
                    rd_byte_q <= rd_data;
                  end
                  else
                    st_q <= SSR_IDLE;
                end
                SSR_ADRH:
                begin
                  // high byte first, top three bits dropped
                  ptr_q <= {sh_next[SSR_ADDR_W-9:0], ptr_q[7:0]};
                  ack_q <= 1'b1;
                  st_q <= SSR_ADRL;
                end
                SSR_ADRL:
                begin
                  ptr_q <= {ptr_q[SSR_ADDR_W-1:8], sh_next};
                  ack_q <= 1'b1;
                  st_q <= SSR_WDAT;
                end
                default:
                begin
                  if (prot_hit)
                    st_q <= SSR_IDLE;
                  else
                  begin
                    ack_q <= 1'b1;
                    wr_pend_q <= 1'b1;
                    wreq_q <= '{addr: ptr_q, data: sh_next};
                  end
                end
              endcase
            end
          end
          SSR_RDAT:
          begin
            // bits shifted out on falling edge; count here
            bit_q <= bit_q + 3'h1;
            if (byte_done)
            begin
              st_q <= SSR_MACK;
              ptr_q <= ptr_inc;
            end
          end
          SSR_MACK:
          begin
            if (!sda_in)
            begin
              st_q <= SSR_RDAT;
              rd_byte_q <= rd_data;
            end
            else
              st_q <= SSR_IDLE;
          end
          default:
            st_q <= SSR_IDLE;
        endcase
      end
      // commit at ack rising edge, then advance
      // only a data byte ack commits; address acks leave the pointer alone
      if (wr_pend_q && !lk_abort && !start_seen)
      begin
        wr_tgl_q <= ~wr_tgl_q;
        ptr_q <= ptr_inc;
      end
    end
  end

  // ------------------------------------------------------------
  // sda driver (scl falling edges)
  // ------------------------------------------------------------
  logic drv_low_q;
  logic [2:0] obit_q;
  always_ff @(negedge scl_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      drv_low_q <= 1'b0;
      obit_q <= SSR_BIT_ZERO;
    end
    else if (ack_q)
    begin
      drv_low_q <= 1'b1;
      obit_q <= SSR_BIT_ZERO;
    end
    else if (st_q == SSR_RDAT)
    begin
      drv_low_q <= ~rd_byte_q[SSR_BIT_LAST - obit_q];
      obit_q <= obit_q + 3'h1;
    end
    else
      drv_low_q <= 1'b0;
  end
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drv_low_q;

  // ------------------------------------------------------------
  // array on system clock, write request crossed by toggle
  // ------------------------------------------------------------
  logic [SSR_DATA_W-1:0] mem_q [SSR_DEPTH];
  logic [0:0] wr_tgl_s;
  ssr_sync #(.WIDTH(1)) u_sync_wr (
    .clk(clk),
    .rst(sys_rst),
    .ce(clk_en),
    .din(wr_tgl_q),
    .dout(wr_tgl_s)
  );
  logic wr_seen_q;
  logic [1:0] act_s;
  ssr_sync #(.WIDTH(2)) u_sync_act (
    .clk(clk),
    .rst(sys_rst),
    .ce(clk_en),
    .din({start_tgl_q, stop_tgl_q}),
    .dout(act_s)
  );
  wire wr_fire = wr_tgl_s[0] ^ wr_seen_q;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_seen_q <= 1'b0;
      link_active_q <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_seen_q <= wr_tgl_s[0];
      link_active_q <= act_s[1] ^ act_s[0];
    end
  end
  // wreq_q is stable for many clk cycles once toggle is seen
  always_ff @(posedge clk)
  begin
    if (clk_en && wr_fire)
      mem_q[wreq_q.addr] <= wreq_q.data;
  end
  // read path is quasi-static: pointer settles long before the scl edge that samples it
  assign rd_data = mem_q[ptr_q];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_nack_busy;
    @(posedge scl_clk) disable iff (sys_rst)
      (st_q == SSR_CTRL && byte_done && lk_busy && !start_seen && !stop_seen && !lk_abort)
        |=> !ack_q;
  endproperty
  a_nack_busy: assert property (p_nack_busy) else $error("ack while busy");

  property p_prot_nack;
    @(posedge scl_clk) disable iff (sys_rst)
      (st_q == SSR_WDAT && byte_done && prot_hit && !start_seen && !stop_seen && !lk_abort)
        |=> (!ack_q && st_q == SSR_IDLE && $stable(ptr_q));
  endproperty
  a_prot_nack: assert property (p_prot_nack) else $error("protected write acked");

  property p_ptr_inc;
    @(posedge scl_clk) disable iff (sys_rst)
      (wr_pend_q && !lk_abort && !start_seen) |=> (ptr_q == $past(ptr_inc));
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced");

  property p_abort;
    @(posedge scl_clk) disable iff (sys_rst)
      lk_abort |=> (st_q == SSR_IDLE);
  endproperty
  a_abort: assert property (p_abort) else $error("op not abandoned");

  property p_bad_ctrl;
    @(posedge scl_clk) disable iff (sys_rst)
      (st_q == SSR_CTRL && byte_done && !ctrl_ok && !start_seen && !stop_seen && !lk_abort)
        |=> (st_q == SSR_IDLE && !ack_q);
  endproperty
  a_bad_ctrl: assert property (p_bad_ctrl) else $error("bad control acked");

  property p_mnack;
    @(posedge scl_clk) disable iff (sys_rst)
      (st_q == SSR_MACK && sda_in && !start_seen && !stop_seen && !lk_abort)
        |=> (st_q == SSR_IDLE);
  endproperty
  a_mnack: assert property (p_mnack) else $error("read continued after nack");

  property p_adr_hi;
    @(posedge scl_clk) disable iff (sys_rst)
      (st_q == SSR_ADRH && byte_done && !start_seen && !stop_seen && !lk_abort)
        |=> (ptr_q[SSR_ADDR_W-1:8] == $past(sh_next[SSR_ADDR_W-9:0]) && ack_q);
  endproperty
  a_adr_hi: assert property (p_adr_hi) else $error("address high byte lost");

  property p_rd_inc;
    @(posedge scl_clk) disable iff (sys_rst)
      (st_q == SSR_RDAT && byte_done && !start_seen && !stop_seen && !lk_abort)
        |=> (ptr_q == $past(ptr_inc) && st_q == SSR_MACK);
  endproperty
  a_rd_inc: assert property (p_rd_inc) else $error("read pointer not advanced");

endmodule : ssr_slave

// >>> tb/ssr_master_model.sv
// two-wire bus master model: drives scl and pulls sda low, released line reads high
`timescale 1ns/1ps
module ssr_master_model
(
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // ----------------------------------------
  // timing: a scl period of 160 ns (80 ns in idle_clocks), idle high
  // ----------------------------------------
  int low_ns = 40;

  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // data changes only while scl is low, read back mid-high
  task automatic bit_io(input logic b, output logic r);
    #(low_ns) sda_pull = ~b;
    #40 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
  endtask : bit_io

  // also a repeated start when scl is low
  task automatic start_cond();
    #40 sda_pull = 1'b0;
    #40 scl = 1'b1;
    #40 sda_pull = 1'b1;
    #40 scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    #40 sda_pull = 1'b1;
    #40 scl = 1'b1;
    #40 sda_pull = 1'b0;
    #40;
  endtask : stop_cond

  // clock pulses with sda released, lets the pin synchronisers settle
  task automatic idle_clocks();
    repeat (2)
    begin
      #40 scl = 1'b0;
      #40 scl = 1'b1;
    end
  endtask : idle_clocks

  // msb first, then the device's acknowledge bit
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : send_byte

  // master acknowledge low asks for more, high ends the read
  task automatic recv_byte(input logic more, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, v[i]);
    bit_io(~more, r);
  endtask : recv_byte
endmodule : ssr_master_model

// >>> tb/serial_sram_two_wire_slave_tb.sv
// self-checking testbench for the serial sram two-wire slave
`timescale 1ns/1ps
module serial_sram_two_wire_slave_tb import ssr_pkg::*;;
  logic clk, sys_rst, clk_en, scl_clk, sda_pull, sda_out, sda_oe_n, link_active_q;
  logic chip_select_upper_pin, chip_select_lower_pin, write_protect_pin;
  logic supply_below_trip, backup_busy, power_loss_backup;
  int num_errors = 0;
  int num_checks = 0;
  // open-drain wire with pull-up
  wire sda = (sda_pull | (~sda_oe_n & ~sda_out)) ? 1'b0 : 1'b1;

  ssr_slave i_ssr_slave (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .scl_clk(scl_clk),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .chip_select_upper_pin(chip_select_upper_pin),
    .chip_select_lower_pin(chip_select_lower_pin), .write_protect_pin(write_protect_pin),
    .supply_below_trip(supply_below_trip), .backup_busy(backup_busy),
    .power_loss_backup(power_loss_backup), .link_active_q(link_active_q));
  ssr_master_model i_ssr_master_model (.scl(scl_clk), .sda_pull(sda_pull), .sda(sda));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [7:0] ctrl(input logic [1:0] cs, input logic rw);
    return {4'ha, cs, 1'b1, rw};
  endfunction : ctrl

  // pins order: upper, lower, protect, trip, busy, backup
  task automatic pins(input logic [5:0] v);
    @(posedge clk);
    {chip_select_upper_pin, chip_select_lower_pin, write_protect_pin, supply_below_trip,
      backup_busy, power_loss_backup} <= v;
  endtask : pins

  task automatic tx(input logic [7:0] v, input logic exp_ack);
    logic a;
    i_ssr_master_model.send_byte(v, a);
    check({15'h0000, a}, {15'h0000, exp_ack});
  endtask : tx

  task automatic rx(input logic more, input logic [7:0] exp);
    logic [7:0] v;
    i_ssr_master_model.recv_byte(more, v);
    check({8'h00, v}, {8'h00, exp});
    if (!more)
    begin
      #1;
      check({15'h0000, sda_oe_n}, 16'h0001);
    end
  endtask : rx

  // top bits of the high byte set on purpose, they must be dropped
  task automatic open_wr(input logic [12:0] a);
    i_ssr_master_model.start_cond();
    tx(ctrl(2'h2, 1'b0), 1'b1);
    tx({3'h7, a[12:8]}, 1'b1);
    tx(a[7:0], 1'b1);
  endtask : open_wr

  task automatic open_rd();
    i_ssr_master_model.start_cond();
    tx(ctrl(2'h2, 1'b1), 1'b1);
  endtask : open_rd

  task automatic stop();
    i_ssr_master_model.stop_cond();
  endtask : stop

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_seq_write_random_read();
    open_wr(13'h0123);
    tx(8'h11, 1'b1);
    tx(8'h22, 1'b1);
    tx(8'h33, 1'b1);
    stop();
    open_wr(13'h0123);
    open_rd();
    rx(1'b1, 8'h11);
    rx(1'b1, 8'h22);
    rx(1'b0, 8'h33);
    stop();
  endtask : s_seq_write_random_read

  task automatic s_byte_write_pointer();
    open_wr(13'h0300);
    tx(8'h77, 1'b1);
    tx(8'h88, 1'b1);
    stop();
    open_wr(13'h0300);
    tx(8'h99, 1'b1);
    stop();
    open_rd();
    rx(1'b0, 8'h88);
    stop();
  endtask : s_byte_write_pointer

  task automatic s_wrap();
    open_wr(13'h1fff);
    tx(8'he1, 1'b1);
    tx(8'he2, 1'b1);
    stop();
    open_wr(13'h1fff);
    open_rd();
    rx(1'b1, 8'he1);
    rx(1'b0, 8'he2);
    stop();
  endtask : s_wrap

  task automatic s_protect();
    open_wr(13'h1800);
    tx(8'h5c, 1'b1);
    stop();
    pins(6'h28);
    open_wr(13'h17ff);
    tx(8'h44, 1'b1);
    tx(8'h66, 1'b0);
    tx(8'h67, 1'b0);
    stop();
    open_rd();
    rx(1'b0, 8'h5c);
    stop();
    pins(6'h20);
    open_wr(13'h17ff);
    open_rd();
    rx(1'b0, 8'h44);
    stop();
  endtask : s_protect

  task automatic s_select();
    for (int p = 0; p < 4; p++)
    begin
      pins({p[1:0], 4'h0});
      for (int c = 0; c < 4; c++)
      begin
        i_ssr_master_model.start_cond();
        tx(ctrl(c[1:0], 1'b0), c == p);
        if (c != p)
          tx(8'h00, 1'b0);
        stop();
      end
    end
    pins(6'h20);
    i_ssr_master_model.start_cond();
    tx({4'hb, 2'h2, 1'b1, 1'b0}, 1'b0);
    stop();
    i_ssr_master_model.start_cond();
    tx({4'ha, 2'h2, 1'b0, 1'b0}, 1'b0);
    stop();
  endtask : s_select

  task automatic s_refuse();
    pins(6'h24);
    i_ssr_master_model.start_cond();
    tx(ctrl(2'h2, 1'b0), 1'b0);
    stop();
    pins(6'h22);
    i_ssr_master_model.start_cond();
    tx(ctrl(2'h2, 1'b0), 1'b0);
    stop();
    pins(6'h20);
  endtask : s_refuse

  task automatic s_abort();
    open_wr(13'h0400);
    tx(8'h12, 1'b1);
    pins(6'h21);
    tx(8'h34, 1'b0);
    stop();
    pins(6'h20);
    i_ssr_master_model.idle_clocks();
    open_wr(13'h0400);
    open_rd();
    rx(1'b0, 8'h12);
    stop();
  endtask : s_abort

  initial
  begin
    repeat (90000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  initial
  begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    {chip_select_upper_pin, chip_select_lower_pin, write_protect_pin, supply_below_trip,
      backup_busy, power_loss_backup} = 6'h20;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    i_ssr_master_model.idle_clocks();
    s_seq_write_random_read();
    s_byte_write_pointer();
    s_wrap();
    s_protect();
    s_select();
    s_refuse();
    s_abort();
    tally_and_finish();
  end
endmodule : serial_sram_two_wire_slave_tb
